// ==== mbs_server.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Single write: address, 0x06, register address, value, high bytes first, CRC.
// - Address zero is a broadcast for single and multiple writes; write applied.
// - Address field is holding register number minus 40001.
// - Single write value is exactly two bytes, stored as one word.
// - Good single write and diagnostics are echoed byte for byte.
// - Broadcast writes are performed but never answered.
// - Diagnostics 0x08 with sub-function 0x0000 echoes the query.
// - Diagnostics to address zero is invalid and not executed.
// - Diagnostics data is any two-byte value, returned unaltered.
// - Multiple write: address, 0x10, start, count, byte count, values, CRC.
// - Register count one up to 125 must be handled.
// - Byte count 0x02 to 0xFA, equal to twice the register count.
// - Words arrive high byte first, stored ascending from start address.
// - Multiple write answer: address, function, start, count, then CRC.
// - Illegal function, address or value gives function plus 0x80 and code.
// - Frames with line or CRC errors, or while busy, dropped silently.
module mbs_server import mbs_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Station
   input wire logic [7:0] own_addr,
   // Receive byte stream
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   input wire logic rx_err,
   input wire logic rx_end,
   // Transmit byte stream
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   // Holding register write port
   output logic wr_en,
   output logic [15:0] wr_addr,
   output logic [15:0] wr_data
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_RX, ST_WR, ST_TX} mbs_phase_t;

   typedef struct packed {
      mbs_phase_t st;
      logic [8:0] cnt;
      logic drop;
      logic [6:0][7:0] hdr;
      logic [MAX_REGS_N-1:0][15:0] data;
      logic [7:0] hi;
      logic [6:0] widx;
      logic [6:0] nwr;
      logic bcast;
      logic [5:0][7:0] resp;
      logic [2:0] rlen;
      logic [2:0] tidx;
      logic [15:0] tcrc;
      logic [7:0] tx_data;
      logic tx_valid;
      logic wr_en;
      logic [15:0] wr_addr;
      logic [15:0] wr_data;
   } mbs_state_t;

   mbs_state_t s_reg, s_next;
   logic crc_clr, crc_en;
   logic [15:0] rx_crc;
   logic [15:0] tx_crc_next;
   logic [8:0] k;
   logic [7:0] fn, exc;
   logic [15:0] start, count;
   logic [16:0] top;
   logic bc, mine, act_wr, act_tx;

   mbs_crc16 u_rx_crc (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clear(crc_clr),
      .en(crc_en),
      .data(rx_byte),
      .crc(rx_crc)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.wr_en = 1'b0;
      crc_clr = 1'b0;
      crc_en = 1'b0;
      k = s_reg.cnt - DATA_POS;
      fn = s_reg.hdr[1];
      start = {s_reg.hdr[2], s_reg.hdr[3]};
      count = {s_reg.hdr[4], s_reg.hdr[5]};
      top = {1'b0, start} + {1'b0, count};
      bc = (s_reg.hdr[0] == BCAST_ADDR);
      mine = (s_reg.hdr[0] == own_addr) || bc;
      exc = EXC_NONE;
      act_wr = 1'b0;
      act_tx = 1'b0;
      tx_crc_next = mbs_crc_step(s_reg.tcrc, s_reg.tx_data);

      // Receive: bytes outside the receive phase poison the frame
      if (rx_valid) begin
         if (s_reg.st == ST_RX && !s_reg.drop) begin
            crc_en = 1'b1;
            s_next.cnt = s_reg.cnt + 9'h001;
            if (s_reg.cnt == FRAME_MAX) begin
               s_next.drop = 1'b1;
            end
            if (s_reg.cnt < HDR_LEN) begin
               s_next.hdr[s_reg.cnt[2:0]] = rx_byte;
            end
            if (fn == FN_WRITEN && s_reg.cnt >= DATA_POS) begin
               if (!k[0]) begin
                  s_next.hi = rx_byte;
               end else if ({8'h00, k[8:1]} < MAX_REGS) begin
                  s_next.data[k[7:1]] = {s_reg.hi, rx_byte};
               end
            end
         end else begin
            s_next.drop = 1'b1;
         end
      end
      if (rx_err) begin
         s_next.drop = 1'b1;
      end

      // Frame end: judge the frame
      if (rx_end) begin
         crc_clr = 1'b1;
         s_next.cnt = 9'h000;
         s_next.drop = 1'b0;
         if (s_reg.st == ST_RX && !s_reg.drop && !rx_err && !rx_valid &&
             s_reg.cnt >= MIN_FRAME && rx_crc == CRC_GOOD && mine) begin
            case (fn)
               FN_WRITE1: begin
                  if (s_reg.cnt == LEN_FIXED) begin
                     // Value field is data, not a count: only the address is range checked
                     if ({1'b0, start} > REG_SPAN - 17'h00001) begin
                        exc = EXC_ADDR;
                     end else begin
                        act_wr = 1'b1;
                     end
                  end
               end
               FN_DIAG: begin
                  if (!bc && s_reg.cnt == LEN_FIXED) begin
                     if (start != DIAG_ECHO_SUB) begin
                        exc = EXC_VALUE;
                     end else begin
                        act_tx = 1'b1;
                     end
                  end
               end
               FN_WRITEN: begin
                  if (count == 16'h0000 || count > MAX_REGS ||
                      {8'h00, s_reg.hdr[6]} != {count[14:0], 1'b0} ||
                      s_reg.cnt != WRITEN_OVH + {1'b0, s_reg.hdr[6]}) begin
                     exc = EXC_VALUE;
                  end else if (top > REG_SPAN) begin
                     exc = EXC_ADDR;
                  end else begin
                     act_wr = 1'b1;
                  end
               end
               default: begin
                  exc = EXC_FUNC;
               end
            endcase
            s_next.bcast = bc;
            s_next.resp = s_reg.hdr[5:0];
            s_next.rlen = RESP_ECHO_LEN;
            if (exc != EXC_NONE) begin
               s_next.resp[1] = fn | FN_EXC_FLAG;
               s_next.resp[2] = exc;
               s_next.rlen = RESP_EXC_LEN;
               act_tx = 1'b1;
            end
            if (act_wr) begin
               s_next.st = ST_WR;
               s_next.widx = 7'h00;
               s_next.nwr = (fn == FN_WRITE1) ? 7'h01 : count[6:0];
            end else if (act_tx && !bc) begin
               s_next.st = ST_TX;
               s_next.tidx = 3'h0;
               s_next.tcrc = CRC_INIT;
               s_next.tx_valid = 1'b1;
               s_next.tx_data = s_next.resp[0];
            end
         end
      end

      // ----------------------------------------------------------------
      // Write and transmit phases
      // ----------------------------------------------------------------
      case (s_reg.st)
         ST_RX: begin
         end
         ST_WR: begin
            s_next.wr_en = 1'b1;
            s_next.wr_addr = start + {9'h000, s_reg.widx};
            s_next.wr_data = (fn == FN_WRITE1) ? count : s_reg.data[s_reg.widx];
            s_next.widx = s_reg.widx + 7'h01;
            if (s_reg.widx == s_reg.nwr - 7'h01) begin
               if (s_reg.bcast) begin
                  s_next.st = ST_RX;
               end else begin
                  s_next.st = ST_TX;
                  s_next.tidx = 3'h0;
                  s_next.tcrc = CRC_INIT;
                  s_next.tx_valid = 1'b1;
                  s_next.tx_data = s_reg.resp[0];
               end
            end
         end
         ST_TX: begin
            if (s_reg.tx_valid && tx_ready) begin
               s_next.tidx = s_reg.tidx + 3'h1;
               if (s_reg.tidx < s_reg.rlen) begin
                  s_next.tcrc = tx_crc_next;
               end
               if (s_reg.tidx < s_reg.rlen - 3'h1) begin
                  s_next.tx_data = s_reg.resp[s_reg.tidx + 3'h1];
               end else if (s_reg.tidx == s_reg.rlen - 3'h1) begin
                  s_next.tx_data = tx_crc_next[7:0];
               end else if (s_reg.tidx == s_reg.rlen) begin
                  s_next.tx_data = s_reg.tcrc[15:8];
               end else begin
                  s_next.tx_valid = 1'b0;
                  s_next.st = ST_RX;
               end
            end
         end
         default: begin
            s_next.st = ST_RX;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tx_data = s_reg.tx_data;
   assign tx_valid = s_reg.tx_valid;
   assign wr_en = s_reg.wr_en;
   assign wr_addr = s_reg.wr_addr;
   assign wr_data = s_reg.wr_data;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_bcast_no_reply: assert property (tx_valid |-> !s_reg.bcast)
      else $error("reply sent for a broadcast");
   a_write_func: assert property (wr_en |-> (fn == FN_WRITE1 || fn == FN_WRITEN))
      else $error("write from a non-write request");
   a_single_word: assert property (wr_en && fn == FN_WRITE1 |-> wr_data == count)
      else $error("single write value mismatch");
   a_write_ascend: assert property (wr_en && $past(wr_en) |->
      wr_addr == $past(wr_addr) + 16'h0001)
      else $error("burst addresses not ascending");
   a_count_limit: assert property (s_reg.st == ST_WR |-> {9'h000, s_reg.widx} < MAX_REGS)
      else $error("write index past limit");
   a_crc_low: assert property (s_reg.st == ST_TX && tx_valid && tx_ready &&
      s_reg.tidx == s_reg.rlen - 3'h1 |=> tx_data == s_reg.tcrc[7:0])
      else $error("crc low byte wrong");
   a_exc_code: assert property (tx_valid && s_reg.resp[1][7] |->
      s_reg.resp[2] >= EXC_FUNC && s_reg.resp[2] <= EXC_VALUE)
      else $error("bad exception code");
   a_diag_bcast: assert property (tx_valid |-> s_reg.resp[0] != BCAST_ADDR)
      else $error("answer to address zero");
   a_busy_drop: assert property (rx_valid && !rx_end && s_reg.st != ST_RX |=>
      s_reg.drop)
      else $error("busy byte not dropped");
   a_tx_len: assert property ($rose(tx_valid) |-> ##[1:40] !tx_valid || !tx_ready)
      else $error("transmit overrun");

   c_single_write: cover property (wr_en && fn == FN_WRITE1 ##[1:20] tx_valid);
   c_burst_write: cover property (wr_en [*3]);
   c_exception: cover property (tx_valid && s_reg.resp[1][7]);
   c_bcast_write: cover property (wr_en && s_reg.bcast);
endmodule

// ==== mbs_pkg.sv ====
package mbs_pkg;
   // ----------------------------------------------------------------
   // Frame codes
   // ----------------------------------------------------------------
   localparam logic [7:0] BCAST_ADDR = 8'h00;
   localparam logic [7:0] FN_WRITE1 = 8'h06;
   localparam logic [7:0] FN_DIAG = 8'h08;
   localparam logic [7:0] FN_WRITEN = 8'h10;
   localparam logic [7:0] FN_EXC_FLAG = 8'h80;
   localparam logic [15:0] DIAG_ECHO_SUB = 16'h0000;
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_ADDR = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam logic [8:0] LEN_FIXED = 9'h008;
   localparam logic [8:0] MIN_FRAME = 9'h004;
   localparam logic [8:0] HDR_LEN = 9'h007;
   localparam logic [8:0] DATA_POS = 9'h007;
   localparam logic [8:0] FRAME_MAX = 9'h103;
   localparam logic [8:0] WRITEN_OVH = 9'h009;
   localparam logic [15:0] MAX_REGS = 16'h007D;
   localparam int MAX_REGS_N = 125;
   // First holding register number that field value zero selects
   localparam int HOLD_REG_BASE = 40001;
   // Number of holding registers behind the write port
   localparam logic [16:0] REG_SPAN = 17'h10000;
   localparam logic [2:0] RESP_ECHO_LEN = 3'h6;
   localparam logic [2:0] RESP_EXC_LEN = 3'h3;

   // ----------------------------------------------------------------
   // Frame check
   // ----------------------------------------------------------------
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_GOOD = 16'h0000;

   function automatic logic [15:0] mbs_crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] x;
      x = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction
endpackage

// ==== mbs_crc16.sv ====
`timescale 1ns/1ps
module mbs_crc16 import mbs_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Byte stream
   input wire logic clear,
   input wire logic en,
   input wire logic [7:0] data,
   // Running residue
   output logic [15:0] crc
);
   always_ff @(posedge ref_clk) begin
      if (!resetn || clear) begin
         crc <= CRC_INIT;
      end else if (en) begin
         crc <= mbs_crc_step(crc, data);
      end
   end
endmodule

// ==== mbs_client.sv ====
`timescale 1ns/1ps
module mbs_client (
   // Clock
   input wire logic ref_clk,
   // Request stream into the server
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic rx_err,
   output logic rx_end,
   // Response stream from the server
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   logic [7:0] rsp_q[$];
   logic slow;

   initial begin
      rx_byte = 8'h00;
      rx_valid = 1'b0;
      rx_err = 1'b0;
      rx_end = 1'b0;
      tx_ready = 1'b0;
      slow = 1'b0;
   end

   // A byte counts only at the edge where valid and ready meet
   always @(posedge ref_clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rsp_q.push_back(tx_data);
   end

   // Slow mode stalls every other cycle, mid-frame too
   always @(negedge ref_clk) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end

   // Line errors can be flagged on any byte of the frame
   task automatic send(input logic [7:0] f[$], input int err_at);
      for (int i = 0; i < f.size(); i++) begin
         @(negedge ref_clk);
         rx_byte <= f[i];
         rx_valid <= 1'b1;
         rx_err <= (i == err_at);
      end
      // End cycle shows the inverse so a stale byte cannot pass
      @(negedge ref_clk);
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      rx_byte <= ~f[f.size() - 1];
      rx_end <= 1'b1;
      @(negedge ref_clk);
      rx_end <= 1'b0;
      rx_byte <= f[f.size() - 1];
   endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import mbs_pkg::*;

   typedef struct {
      logic [7:0] adr;
      logic [7:0] fn;
      logic [15:0] a;
      logic [15:0] b;
      logic [7:0] exc;
   } mbs_row_t;

   localparam logic [7:0] SILENT = 8'hFF;

   logic ref_clk;
   logic resetn = 1'b0;
   logic [7:0] own_addr = 8'h05;
   logic [7:0] rx_byte;
   logic rx_valid;
   logic rx_err;
   logic rx_end;
   logic [7:0] tx_data;
   logic tx_valid;
   logic tx_ready;
   logic wr_en;
   logic [15:0] wr_addr;
   logic [15:0] wr_data;
   logic [31:0] wq[$];
   int n_fail = 0;
   int samples_checked = 0;

   // ----------------------------------------------------------------
   // Ordinary cases
   // ----------------------------------------------------------------
   mbs_row_t rows[14] = '{
      '{8'h05, FN_WRITE1, 16'h000D, 16'h1770, EXC_NONE},
      '{8'h00, FN_WRITE1, 16'h0001, 16'hABCD, SILENT},
      '{8'h05, FN_DIAG, 16'h0000, 16'hFFFF, EXC_NONE},
      '{8'h05, FN_DIAG, 16'h0000, 16'h0000, EXC_NONE},
      '{8'h00, FN_DIAG, 16'h0000, 16'h1234, SILENT},
      '{8'h05, FN_WRITEN, 16'h03EE, 16'h0002, EXC_NONE},
      '{8'h00, FN_WRITEN, 16'h0100, 16'h0003, SILENT},
      '{8'h05, FN_WRITEN, 16'h0000, 16'h007D, EXC_NONE},
      '{8'h05, FN_WRITEN, 16'h0000, 16'h007E, EXC_VALUE},
      '{8'h05, FN_WRITEN, 16'h0000, 16'h0000, EXC_VALUE},
      '{8'h05, FN_WRITEN, 16'hFFFF, 16'h0002, EXC_ADDR},
      '{8'h05, FN_DIAG, 16'h0001, 16'h0000, EXC_VALUE},
      '{8'h05, 8'h03, 16'h0000, 16'h0001, EXC_FUNC},
      '{8'h05, FN_WRITE1, 16'hFFFF, 16'h0001, EXC_NONE}
   };

   mbs_server DUT (.ref_clk(ref_clk), .resetn(resetn), .own_addr(own_addr),
      .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_err(rx_err), .rx_end(rx_end),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

   mbs_client cl (.ref_clk(ref_clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .rx_err(rx_err), .rx_end(rx_end), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});
   end

   function automatic logic [15:0] crc_of(input logic [7:0] f[$]);
      logic [15:0] c;
      c = CRC_INIT;
      foreach (f[i]) begin
         c = c ^ {8'h00, f[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk_wr(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic print_verdict();
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Bad: 0 clean, 1 line error on third byte, 2 corrupted high check byte
   task automatic run_row(input mbs_row_t r, input logic slow, input int bad);
      logic [7:0] q[$];
      logic [7:0] e[$];
      logic [31:0] we[$];
      logic [15:0] c;
      logic [15:0] w;
      int n;
      q = '{r.adr, r.fn, r.a[15:8], r.a[7:0], r.b[15:8], r.b[7:0]};
      if (r.fn == FN_WRITEN) begin
         q.push_back(8'(r.b << 1));
         // Oversize counts send no extra words, so the frame stays within the longest one
         for (int i = 0; i < int'(r.b) && i < MAX_REGS_N; i++) begin
            w = 16'hA500 ^ 16'(i);
            q.push_back(w[15:8]);
            q.push_back(w[7:0]);
            we.push_back({16'(r.a + 16'(i)), w});
         end
      end else if (r.fn == FN_WRITE1) we.push_back({r.a, r.b});
      if (r.exc != EXC_NONE && r.exc != SILENT || r.fn == FN_DIAG || bad != 0) we.delete();
      c = crc_of(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      if (r.exc == EXC_NONE && r.fn == FN_WRITEN) e = q[0:5];
      else if (r.exc == EXC_NONE) e = q;
      else if (r.exc != SILENT) e = '{r.adr, r.fn | FN_EXC_FLAG, r.exc};
      if (r.exc != EXC_NONE || r.fn == FN_WRITEN) begin
         c = crc_of(e);
         if (e.size() > 0) e = {e, c[7:0], c[15:8]};
      end
      if (bad != 0) e.delete();
      if (bad == 2) q[q.size() - 1] = q[q.size() - 1] ^ 8'h01;
      cl.rsp_q.delete();
      wq.delete();
      cl.slow = slow;
      cl.send(q, (bad == 1) ? 2 : -1);
      n = 0;
      // Broadcasts give no reply, so the processing time is waited out
      while (n < 3000 && (n < we.size() + 4 || cl.rsp_q.size() < e.size()
            || tx_valid !== 1'b0)) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 3000) begin
         n_fail++;
         $display("CHECK FAILED completion expected idle seen busy");
         print_verdict();
      end
      chk_wr("write count", 32'(we.size()), 32'(wq.size()));
      foreach (we[k]) if (k < wq.size()) chk_wr("write", we[k], wq[k]);
      chk_wr("reply length", 32'(e.size()), 32'(cl.rsp_q.size()));
      foreach (e[k]) if (k < cl.rsp_q.size())
         chk_byte("reply", e[k], cl.rsp_q[k]);
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] bq[$];
      logic [15:0] bcrc;
      repeat (3) @(negedge ref_clk);
      chk_byte("reset flags", 8'h00, {tx_valid, wr_en, 6'h00});
      chk_wr("reset write port", 32'h0, {wr_addr, wr_data});
      resetn <= 1'b1;
      for (int i = 0; i < 14; i++) run_row(rows[i], i[0], 0);
      run_row(rows[0], 1'b0, 1);
      run_row(rows[5], 1'b1, 2);
      run_row(rows[1], 1'b0, 2);
      run_row(rows[7], 1'b1, 0);
      // Busy: a second frame arriving during a slow reply is dropped whole
      bq = '{8'h05, FN_DIAG, 8'h00, 8'h00, 8'h5A, 8'hC3};
      bcrc = crc_of(bq);
      bq = {bq, bcrc[7:0], bcrc[15:8]};
      cl.rsp_q.delete();
      cl.slow = 1'b1;
      cl.send(bq, -1);
      cl.send(bq, -1);
      repeat (30) @(posedge ref_clk);
      chk_wr("busy reply length", 32'h8, 32'(cl.rsp_q.size()));
      foreach (bq[k]) if (k < cl.rsp_q.size())
         chk_byte("busy reply", bq[k], cl.rsp_q[k]);
      print_verdict();
   end
endmodule
